/* File: src/sysconf_pkg.sv */
/*
 * Constants and carrier types for the system configuration register bank.
 * Assumes a classic Wishbone master that presents byte offsets inside the
 * bank and a peripheral request set on the same clock as the bank.
 */
package sysconf_pkg;

	// ------------------------------------------------------------------
	// Register offsets (byte addresses within the bank)
	// ------------------------------------------------------------------
	localparam logic [5:0] OFS_MAP_CFG      = 6'h00;
	localparam logic [5:0] OFS_IRQ_SEL_A    = 6'h08;
	localparam logic [5:0] OFS_IRQ_SEL_B    = 6'h0C;
	localparam logic [5:0] OFS_IRQ_SEL_C    = 6'h10;
	localparam logic [5:0] OFS_IRQ_SEL_D    = 6'h14;
	localparam logic [5:0] OFS_BRAKE_CFG    = 6'h18;
	localparam logic [5:0] OFS_DATA_KEY     = 6'h20;
	localparam logic [5:0] OFS_INSTR_KEY    = 6'h24;
	localparam logic [5:0] OFS_SCRAMBLE_EN  = 6'h28;
	localparam logic [5:0] OFS_ACCESS       = 6'h2C;

	// ------------------------------------------------------------------
	// Field positions in memory_and_remap_config and the brake configuration register
	// ------------------------------------------------------------------
	localparam int POS_MAP_SEL_LO = 0;
	localparam int POS_IR_SRC     = 6;
	localparam int POS_CONV_RMP   = 8;
	localparam int POS_SER_TX_RMP = 9;
	localparam int POS_SER_RX_RMP = 10;
	localparam int POS_FMP_LO     = 16;
	localparam int POS_SPI_RMP    = 22;
	localparam int POS_I2C_RMP    = 27;
	localparam int POS_ADV_RMP    = 28;
	localparam int POS_GPA_RMP    = 29;
	localparam int POS_GPB_RMP    = 30;
	localparam int FMP_PINS       = 6;
	localparam int POS_LOCKUP_LNK = 0;
	localparam int POS_SUPPLY_LNK = 2;

	// ------------------------------------------------------------------
	// Implemented-bit masks and values after reset
	// ------------------------------------------------------------------
	localparam logic [31:0] MASK_MAP_CFG     = 32'h787F0743;
	localparam logic [31:0] MASK_IRQ_SEL     = 32'h00007FFF;
	localparam logic [31:0] MASK_BRAKE_CFG   = 32'h00000005;
	localparam logic [31:0] MASK_SCRAMBLE_EN = 32'h00000003;
	localparam logic [31:0] MASK_ACCESS      = 32'hFFFFEEC9;
	localparam logic [31:0] RST_ZERO         = 32'h00000000;
	localparam logic [31:0] RST_SCRAMBLE_EN  = 32'h00000004;
	localparam logic [31:0] RST_ACCESS       = 32'h17FFEEC9;

	typedef enum logic [1:0] {
		MAP_MAIN_FLASH = 2'b00,
		MAP_SYS_FLASH  = 2'b01,
		MAP_MAIN_ALT   = 2'b10,
		MAP_SRAM       = 2'b11
	} map_sel_type;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [5:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_type;

	// DMA requests from the peripherals, one bit each.
	typedef struct packed {
		logic converter;
		logic serial1_a;
		logic serial1_b;
		logic spi_rx;
		logic spi_tx;
		logic i2c_rx;
		logic i2c_tx;
		logic adv_ch1;
		logic adv_ch2;
		logic adv_ch3;
		logic gpa_ch1;
		logic gpa_ch2;
		logic gpb_ch1;
		logic gpb_ch2;
	} periph_req_type;

endpackage : sysconf_pkg

/* File: src/system_config_remap.sv */
/*
 * System configuration register bank: boot memory selection, infrared
 * envelope source, DMA request remapping, Fast-mode Plus pin drive,
 * interrupt source selectors, brake links, scramble keys and permits.
 * Assumes a classic Wishbone master on i_core_clk, boot pins that are
 * asynchronous to the clock and DMA requests generated on i_core_clk.
 */
// The Wishbone interface to the registers was left to the implementer.
// Operation
// R1: Bits 1:0 select address-zero memory: X0 main, 01 system flash, 11 SRAM.
// R2: Reset loads the map select from boot pins; other bits reset to zero.
// R3: Software may rewrite the map select anytime, overriding the boot choice.
// R4: Bit 6 picks infrared envelope: 0 timer B, 1 serial port one.
// R5: Bit 8 moves converter DMA request from channel 1 to channel 2.
// R6: Bit 9 moves the first serial request from channel 2 to 4.
// R7: Bit 10 moves the second serial request from channel 3 to 5.
// R8: Bits 16 to 19 enable Fast-mode Plus on port B pins 6 to 9.
// R9: Bits 20 and 21 enable Fast-mode Plus on port C pins 4, 5.
// R10: Bit 22 moves SPI receive/transmit from channels 2/3 to 4/5.
// R11: Bit 27 moves I2C receive/transmit from channels 3/2 to 7/6.
// R12: Bit 28 moves advanced timer channels from 2,3,5 to channel 6.
// R13: Bit 29 moves timer A channels from 3,4 to channel 7.
// R14: Bit 30 moves timer B channels from channel 4 to channel 6.
// R15: Word registers decode at 0x00, 0x08-0x14, 0x18, 0x20, 0x24, 0x28, 0x2C.
// R16: Remap bits only redirect requests; clearing restores default channels.
// R17: Reserved bits read as zero and ignore writes.
`timescale 1ns/1ps

module system_config_remap
	import sysconf_pkg::*;
(
	input  wire logic                  i_core_clk,    // 250 MHz clock
	input  wire logic                  i_rst_n,       // Sync reset, low
	input  wire logic                  i_clk_en,      // Freezes state low
	input  wire sysconf_pkg::wb_req_type i_wb,        // Bus request
	output logic [31:0]                o_wb_dat,      // Read data
	output logic                       o_wb_ack,      // Bus acknowledge
	input  wire logic [1:0]            i_boot_pins,   // Boot straps
	output logic [1:0]                 o_map_sel,     // Address-zero select
	output logic                       o_map_main,    // Main flash at zero
	output logic                       o_map_sys,     // System flash at zero
	output logic                       o_map_sram,    // SRAM at zero
	input  wire logic                  i_ir_timer,    // Timer B envelope
	input  wire logic                  i_ir_serial,   // Serial envelope
	output logic                       o_ir_envelope, // Selected envelope
	input  wire sysconf_pkg::periph_req_type i_req,   // Peripheral DMA reqs
	output logic [7:1]                 o_dma_req,     // Per-channel requests
	output logic [5:0]                 o_fastplus,    // FM+ pin enables
	output logic [59:0]                o_irq_src_sel, // Line source selects
	output logic                       o_lockup_link, // Lockup to brake
	output logic                       o_supply_link, // Supply alarm to brake
	output logic [31:0]                o_data_key,    // Data scramble key
	output logic [31:0]                o_instr_key,   // Instr scramble key
	output logic [1:0]                 o_scramble_en, // Scramble enables
	output logic [31:0]                o_access       // Access permits
);
	import sysconf_pkg::*;

	// ------------------------------------------------------------------
	// Boot pin synchroniser
	// ------------------------------------------------------------------
	// The straps come from pins, so they pass two flops before reset
	// logic samples them. No reset here: the chain must settle while the
	// bank is still held in reset so the load reflects the real straps.
	logic [1:0] boot_meta_r;
	logic [1:0] boot_sync_r;

	always_ff @(posedge i_core_clk) begin
		if (i_clk_en) begin
			boot_meta_r <= i_boot_pins;
			boot_sync_r <= boot_meta_r;
		end
	end

	// ------------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------------
	logic [31:0] map_cfg_r;
	logic [31:0] irq_sel_r [4];
	logic [31:0] brake_cfg_r;
	logic [31:0] data_key_r;
	logic [31:0] instr_key_r;
	logic [31:0] scramble_en_r;
	logic [31:0] access_r;
	logic        ack_r;
	logic [31:0] rdat_r;

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	wire         req_live  = i_wb.cyc & i_wb.stb & ~ack_r;
	wire         wr_live   = req_live & i_wb.we;
	wire  [31:0] byte_mask = {{8{i_wb.sel[3]}}, {8{i_wb.sel[2]}},
	                          {8{i_wb.sel[1]}}, {8{i_wb.sel[0]}}};

	wire hit_map    = (i_wb.adr == OFS_MAP_CFG); // R15
	wire hit_irq_a  = (i_wb.adr == OFS_IRQ_SEL_A); // R15
	wire hit_irq_b  = (i_wb.adr == OFS_IRQ_SEL_B);
	wire hit_irq_c  = (i_wb.adr == OFS_IRQ_SEL_C);
	wire hit_irq_d  = (i_wb.adr == OFS_IRQ_SEL_D);
	wire hit_brake  = (i_wb.adr == OFS_BRAKE_CFG);
	wire hit_dkey   = (i_wb.adr == OFS_DATA_KEY);
	wire hit_ikey   = (i_wb.adr == OFS_INSTR_KEY);
	wire hit_scr    = (i_wb.adr == OFS_SCRAMBLE_EN);
	wire hit_access = (i_wb.adr == OFS_ACCESS); // R15

	wire [3:0] hit_irq = {hit_irq_d, hit_irq_c, hit_irq_b, hit_irq_a};

	// Merge write data into a register under byte enables and mask.
	function automatic logic [31:0] merge(
		input logic [31:0] old_val,
		input logic [31:0] wdat,
		input logic [31:0] bmask,
		input logic [31:0] impl
	);
		logic [31:0] lanes;
		lanes = bmask & impl;
		merge = (old_val & ~lanes) | (wdat & lanes);
	endfunction : merge

	wire [31:0] map_cfg_nxt   = merge(map_cfg_r, i_wb.dat, byte_mask,
	                                  MASK_MAP_CFG); // R3 R17
	wire [31:0] brake_cfg_nxt = brake_cfg_r |
	                            (i_wb.dat & byte_mask & MASK_BRAKE_CFG);
	wire [31:0] dkey_nxt      = merge(data_key_r, i_wb.dat, byte_mask,
	                                  32'hFFFFFFFF);
	wire [31:0] ikey_nxt      = merge(instr_key_r, i_wb.dat, byte_mask,
	                                  32'hFFFFFFFF);
	wire [31:0] scr_nxt       = merge(scramble_en_r, i_wb.dat, byte_mask,
	                                  MASK_SCRAMBLE_EN);
	wire [31:0] access_nxt    = merge(access_r, i_wb.dat, byte_mask,
	                                  MASK_ACCESS);

	// Reads: scramble keys are write-only and read back as zero. Unmapped
	// offsets are acknowledged with zero so the master never hangs.
	wire [31:0] rdat_nxt;
	assign rdat_nxt =
		hit_map    ? (map_cfg_r & MASK_MAP_CFG) : // R17
		hit_irq_a  ? (irq_sel_r[0] & MASK_IRQ_SEL) :
		hit_irq_b  ? (irq_sel_r[1] & MASK_IRQ_SEL) :
		hit_irq_c  ? (irq_sel_r[2] & MASK_IRQ_SEL) :
		hit_irq_d  ? (irq_sel_r[3] & MASK_IRQ_SEL) :
		hit_brake  ? (brake_cfg_r & MASK_BRAKE_CFG) :
		hit_scr    ? (scramble_en_r & MASK_SCRAMBLE_EN) :
		hit_access ? (access_r & MASK_ACCESS) :
		RST_ZERO;

	// ------------------------------------------------------------------
	// Bus handshake
	// ------------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			ack_r  <= 1'b0;
			rdat_r <= RST_ZERO;
		end else if (i_clk_en) begin
			ack_r  <= req_live;
			if (req_live && !i_wb.we) begin
				rdat_r <= rdat_nxt;
			end
		end
	end

	// ------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			map_cfg_r <= {30'h00000000, boot_sync_r}; // R2
		end else if (i_clk_en && wr_live && hit_map) begin
			map_cfg_r <= map_cfg_nxt; // R3
		end
	end

	for (genvar g = 0; g < 4; g++) begin : g_irq_sel
		always_ff @(posedge i_core_clk) begin
			if (!i_rst_n) begin
				irq_sel_r[g] <= RST_ZERO;
			end else if (i_clk_en && wr_live && hit_irq[g]) begin
				irq_sel_r[g] <= merge(irq_sel_r[g], i_wb.dat,
				                      byte_mask, MASK_IRQ_SEL);
			end
		end
		assign o_irq_src_sel[g*15 +: 15] = irq_sel_r[g][14:0];
	end

	// Brake links can only be set by software; reset alone clears them,
	// so a stray write cannot drop a safety connection.
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			brake_cfg_r   <= RST_ZERO;
			data_key_r    <= RST_ZERO;
			instr_key_r   <= RST_ZERO;
			scramble_en_r <= RST_SCRAMBLE_EN;
			access_r      <= RST_ACCESS;
		end else if (i_clk_en && wr_live) begin
			if (hit_brake) begin
				brake_cfg_r <= brake_cfg_nxt;
			end
			if (hit_dkey) begin
				data_key_r <= dkey_nxt;
			end
			if (hit_ikey) begin
				instr_key_r <= ikey_nxt;
			end
			if (hit_scr) begin
				scramble_en_r <= scr_nxt;
			end
			if (hit_access) begin
				access_r <= access_nxt;
			end
		end
	end

	// ------------------------------------------------------------------
	// Memory map decode
	// ------------------------------------------------------------------
	wire [1:0] map_sel = map_cfg_r[POS_MAP_SEL_LO +: 2];
	wire       sel_main = ~map_sel[0]; // R1
	wire       sel_sys  = (map_sel == MAP_SYS_FLASH); // R1
	wire       sel_sram = (map_sel == MAP_SRAM); // R1

	// ------------------------------------------------------------------
	// DMA request routing
	// ------------------------------------------------------------------
	wire rmp_conv = map_cfg_r[POS_CONV_RMP];
	wire rmp_sa   = map_cfg_r[POS_SER_TX_RMP];
	wire rmp_sb   = map_cfg_r[POS_SER_RX_RMP];
	wire rmp_spi  = map_cfg_r[POS_SPI_RMP];
	wire rmp_i2c  = map_cfg_r[POS_I2C_RMP];
	wire rmp_adv  = map_cfg_r[POS_ADV_RMP];
	wire rmp_gpa  = map_cfg_r[POS_GPA_RMP];
	wire rmp_gpb  = map_cfg_r[POS_GPB_RMP];
	wire gpb_any  = i_req.gpb_ch1 | i_req.gpb_ch2;

	// Each request lands on exactly one channel; clearing a bit puts it
	// back on its default channel with no other side effect.
	wire [7:1] route;
	assign route[1] = i_req.converter & ~rmp_conv; // R5 R16
	assign route[2] = (i_req.converter & rmp_conv) | // R5
	                  (i_req.serial1_a & ~rmp_sa) | // R6
	                  (i_req.spi_rx & ~rmp_spi) | // R10
	                  (i_req.i2c_tx & ~rmp_i2c) | // R11
	                  (i_req.adv_ch1 & ~rmp_adv); // R12
	assign route[3] = (i_req.serial1_b & ~rmp_sb) | // R7
	                  (i_req.spi_tx & ~rmp_spi) | // R10
	                  (i_req.i2c_rx & ~rmp_i2c) | // R11
	                  (i_req.adv_ch2 & ~rmp_adv) | // R12
	                  (i_req.gpa_ch1 & ~rmp_gpa); // R13
	assign route[4] = (i_req.serial1_a & rmp_sa) | // R6
	                  (i_req.spi_rx & rmp_spi) | // R10
	                  (i_req.gpa_ch2 & ~rmp_gpa) | // R13
	                  (gpb_any & ~rmp_gpb); // R14
	assign route[5] = (i_req.serial1_b & rmp_sb) | // R7
	                  (i_req.spi_tx & rmp_spi) | // R10
	                  (i_req.adv_ch3 & ~rmp_adv); // R12
	assign route[6] = (i_req.i2c_tx & rmp_i2c) | // R11
	                  ((i_req.adv_ch1 | i_req.adv_ch2 | i_req.adv_ch3) &
	                   rmp_adv) | // R12
	                  (gpb_any & rmp_gpb); // R14
	assign route[7] = (i_req.i2c_rx & rmp_i2c) | // R11
	                  ((i_req.gpa_ch1 | i_req.gpa_ch2) & rmp_gpa); // R13

	wire ir_nxt = map_cfg_r[POS_IR_SRC] ? i_ir_serial : i_ir_timer; // R4

	// ------------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------------
	// Routed requests and the envelope are retimed: one cycle of latency
	// buys a clean flop-driven output toward the DMA and the IR driver.
	logic [7:1] dma_req_r;
	logic       ir_r;
	logic [2:0] map_onehot_r;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			dma_req_r    <= 7'h00;
			ir_r         <= 1'b0;
			map_onehot_r <= 3'h0;
		end else if (i_clk_en) begin
			dma_req_r    <= route;
			ir_r         <= ir_nxt;
			map_onehot_r <= {sel_sram, sel_sys, sel_main};
		end
	end

	assign o_wb_ack      = ack_r;
	assign o_wb_dat      = rdat_r;
	assign o_map_sel     = map_sel;
	assign o_map_main    = map_onehot_r[0];
	assign o_map_sys     = map_onehot_r[1];
	assign o_map_sram    = map_onehot_r[2];
	assign o_ir_envelope = ir_r;
	assign o_dma_req     = dma_req_r;
	assign o_fastplus    = map_cfg_r[POS_FMP_LO +: FMP_PINS]; // R8 R9
	assign o_lockup_link = brake_cfg_r[POS_LOCKUP_LNK];
	assign o_supply_link = brake_cfg_r[POS_SUPPLY_LNK];
	assign o_data_key    = data_key_r;
	assign o_instr_key   = instr_key_r;
	assign o_scramble_en = scramble_en_r[1:0];
	assign o_access      = access_r & MASK_ACCESS;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	a_boot_load: assert property (@(posedge i_core_clk) // R2
		(!i_rst_n && i_clk_en) |=> (o_map_sel == $past(boot_sync_r)) &&
		(map_cfg_r[31:2] == 30'h00000000))
		else $error("map select not loaded from boot pins");

	a_map_write: assert property (@(posedge i_core_clk) // R3
		disable iff (!i_rst_n)
		(i_clk_en && wr_live && hit_map && i_wb.sel[0]) |=>
		(o_map_sel == $past(i_wb.dat[1:0])))
		else $error("map select write lost");

	a_map_decode: assert property (@(posedge i_core_clk) // R1
		disable iff (!i_rst_n)
		(i_clk_en && $stable(o_map_sel)) |=>
		(o_map_main == !$past(o_map_sel[0])) &&
		(o_map_sys == ($past(o_map_sel) == 2'b01)) &&
		(o_map_sram == ($past(o_map_sel) == 2'b11)))
		else $error("address-zero memory decode wrong");

	a_ir_source: assert property (@(posedge i_core_clk) // R4
		disable iff (!i_rst_n)
		i_clk_en |=> (o_ir_envelope == ($past(map_cfg_r[6]) ?
		$past(i_ir_serial) : $past(i_ir_timer))))
		else $error("infrared envelope source wrong");

	a_conv_route: assert property (@(posedge i_core_clk) // R5
		disable iff (!i_rst_n)
		(i_clk_en && i_req.converter && !rmp_conv) |=> o_dma_req[1])
		else $error("converter request not on channel 1");

	a_serial_route: assert property (@(posedge i_core_clk) // R6
		disable iff (!i_rst_n)
		(i_clk_en && i_req == 14'h1000 && rmp_sa) |=>
		(o_dma_req == 7'h08))
		else $error("serial request not only on channel 4");

	a_serial_b_route: assert property (@(posedge i_core_clk) // R7
		disable iff (!i_rst_n)
		(i_clk_en && i_req == 14'h0800 && !rmp_sb) |=>
		(o_dma_req == 7'h04))
		else $error("second serial request not only on channel 3");

	a_adv_route: assert property (@(posedge i_core_clk) // R12
		disable iff (!i_rst_n)
		(i_clk_en && i_req.adv_ch3 && rmp_adv) |=>
		o_dma_req[6])
		else $error("advanced timer request not on channel 6");

	a_gpa_route: assert property (@(posedge i_core_clk) // R13
		disable iff (!i_rst_n)
		(i_clk_en && i_req == 14'h0008 && !rmp_gpa) |=>
		(o_dma_req == 7'h04))
		else $error("timer A request not only on channel 3");

	a_no_request: assert property (@(posedge i_core_clk) // R16
		disable iff (!i_rst_n)
		(i_clk_en && i_req == 14'h0000) |=> (o_dma_req == 7'h00))
		else $error("channel request without a source");

	a_reserved_zero: assert property (@(posedge i_core_clk) // R17
		disable iff (!i_rst_n)
		(i_clk_en && req_live && !i_wb.we && hit_map) |=>
		o_wb_ack && ((o_wb_dat & ~MASK_MAP_CFG) == 32'h00000000))
		else $error("reserved bits read non-zero");

	a_key_readback: assert property (@(posedge i_core_clk) // R15
		disable iff (!i_rst_n)
		(i_clk_en && req_live && !i_wb.we && (hit_dkey || hit_ikey)) |=>
		o_wb_ack && (o_wb_dat == 32'h00000000))
		else $error("write-only key read back non-zero");

	a_fastplus_pins: assert property (@(posedge i_core_clk) // R8
		disable iff (!i_rst_n)
		(i_clk_en && wr_live && hit_map && i_wb.sel[2]) |=>
		(o_fastplus == $past(i_wb.dat[21:16])))
		else $error("fast-mode plus enables not updated");

endmodule : system_config_remap

/* File: verif/system_config_remap_tb.sv */
/*
 * Self-checking bench for the system configuration register bank.
 * Assumes one ack per Wishbone access and registered side outputs.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
	errors++; $display("unexpected %s exp %0h got %0h", nm, ex, got); end end

module system_config_remap_tb;
	import sysconf_pkg::*;

	typedef struct packed {
		logic [5:0]  adr;
		logic [3:0]  sel;
		logic [31:0] wdat;
		logic [31:0] ex;
	} row_type;

	logic           i_core_clk;
	logic           i_rst_n;
	logic           i_clk_en;
	wb_req_type     i_wb;
	logic [31:0]    o_wb_dat;
	logic           o_wb_ack;
	logic [1:0]     i_boot_pins;
	logic [1:0]     o_map_sel;
	logic           o_map_main;
	logic           o_map_sys;
	logic           o_map_sram;
	logic           i_ir_timer;
	logic           i_ir_serial;
	logic           o_ir_envelope;
	periph_req_type i_req;
	logic [7:1]     o_dma_req;
	logic [5:0]     o_fastplus;
	logic [59:0]    o_irq_src_sel;
	logic           o_lockup_link;
	logic           o_supply_link;
	logic [31:0]    o_data_key;
	logic [31:0]    o_instr_key;
	logic [1:0]     o_scramble_en;
	logic [31:0]    o_access;
	int             errors;
	int             n_tests;
	logic [31:0]    rd;
	logic [31:0]    cfg;
	row_type        rows [16];

	system_config_remap uut (
		.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
		.i_wb(i_wb), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
		.i_boot_pins(i_boot_pins), .o_map_sel(o_map_sel),
		.o_map_main(o_map_main), .o_map_sys(o_map_sys),
		.o_map_sram(o_map_sram), .i_ir_timer(i_ir_timer),
		.i_ir_serial(i_ir_serial), .o_ir_envelope(o_ir_envelope),
		.i_req(i_req), .o_dma_req(o_dma_req), .o_fastplus(o_fastplus),
		.o_irq_src_sel(o_irq_src_sel), .o_lockup_link(o_lockup_link),
		.o_supply_link(o_supply_link), .o_data_key(o_data_key),
		.o_instr_key(o_instr_key), .o_scramble_en(o_scramble_en),
		.o_access(o_access));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic stop_test;
		$display("tests %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test

	// Read data is the pre-edge value seen at the edge where ack is high.
	task automatic wb(input logic we, input logic [5:0] adr,
		input logic [3:0] sel, input logic [31:0] dat,
		output logic [31:0] rdat);
		@(posedge i_core_clk);
		i_wb <= '{cyc:1'b1, stb:1'b1, we:we, adr:adr, sel:sel, dat:dat};
		do begin
			@(posedge i_core_clk);
		end while (o_wb_ack !== 1'b1);
		rdat = o_wb_dat;
		i_wb.cyc <= 1'b0;
		i_wb.stb <= 1'b0;
	endtask : wb

	task automatic wr(input logic [5:0] adr, input logic [31:0] dat);
		logic [31:0] d;
		wb(1'b1, adr, 4'hF, dat, d);
	endtask : wr

	task automatic chk_rd(input logic [5:0] adr, input logic [31:0] ex);
		logic [31:0] d;
		wb(1'b0, adr, 4'hF, 32'h0, d);
		`CHK("read", ex, d)
	endtask : chk_rd

	task automatic do_reset(input logic [1:0] boot);
		@(posedge i_core_clk);
		i_boot_pins <= boot;
		i_rst_n <= 1'b0;
		repeat (5) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		@(posedge i_core_clk);
		#1;
	endtask : do_reset

	function automatic logic [7:1] route(input logic [31:0] c,
		input periph_req_type r);
		logic [7:0] q;
		q = '0;
		if (r.converter) q[c[8] ? 2 : 1] = 1'b1;
		if (r.serial1_a) q[c[9] ? 4 : 2] = 1'b1;
		if (r.serial1_b) q[c[10] ? 5 : 3] = 1'b1;
		if (r.spi_rx) q[c[22] ? 4 : 2] = 1'b1;
		if (r.spi_tx) q[c[22] ? 5 : 3] = 1'b1;
		if (r.i2c_rx) q[c[27] ? 7 : 3] = 1'b1;
		if (r.i2c_tx) q[c[27] ? 6 : 2] = 1'b1;
		if (r.adv_ch1) q[c[28] ? 6 : 2] = 1'b1;
		if (r.adv_ch2) q[c[28] ? 6 : 3] = 1'b1;
		if (r.adv_ch3) q[c[28] ? 6 : 5] = 1'b1;
		if (r.gpa_ch1) q[c[29] ? 7 : 3] = 1'b1;
		if (r.gpa_ch2) q[c[29] ? 7 : 4] = 1'b1;
		if (r.gpb_ch1 || r.gpb_ch2) q[c[30] ? 6 : 4] = 1'b1;
		return q[7:1];
	endfunction : route

	// ------------------------------------------------------------------
	// Stimulus
	// ------------------------------------------------------------------
	initial begin
		i_core_clk = 1'b0;
		forever #2 i_core_clk = ~i_core_clk;
	end

	initial begin
		#100000;
		errors++;
		stop_test();
	end

	initial begin
		errors = 0;
		n_tests = 0;
		i_rst_n = 1'b0;
		i_clk_en = 1'b1;
		i_wb = '0;
		i_req = '0;
		i_ir_timer = 1'b0;
		i_ir_serial = 1'b0;
		i_boot_pins = 2'b01;
		rows = '{
			'{6'h00, 4'hF, 32'hFFFFFFFF, 32'h787F0743},
			'{6'h00, 4'hF, 32'h00000000, 32'h00000000},
			'{6'h00, 4'h1, 32'hFFFFFFFF, 32'h00000043},
			'{6'h08, 4'hF, 32'hFFFFFFFF, 32'h00007FFF},
			'{6'h0C, 4'hF, 32'hFFFFFFFF, 32'h00007FFF},
			'{6'h10, 4'hF, 32'hFFFFFFFF, 32'h00007FFF},
			'{6'h14, 4'hF, 32'hFFFFFFFF, 32'h00007FFF},
			'{6'h18, 4'hF, 32'h00000005, 32'h00000005},
			'{6'h18, 4'hF, 32'h00000000, 32'h00000005},
			'{6'h20, 4'hF, 32'h12345678, 32'h00000000},
			'{6'h24, 4'hF, 32'h9ABCDEF0, 32'h00000000},
			'{6'h28, 4'hF, 32'hFFFFFFFF, 32'h00000003},
			'{6'h2C, 4'hF, 32'h00000000, 32'h00000000},
			'{6'h04, 4'hF, 32'hFFFFFFFF, 32'h00000000},
			'{6'h30, 4'hF, 32'hFFFFFFFF, 32'h00000000},
			'{6'h2C, 4'hF, 32'hFFFFFFFF, 32'hFFFFEEC9}};
		do_reset(2'b01);
		`CHK("map_onehot", 3'b010, {o_map_main, o_map_sys, o_map_sram})
		chk_rd(6'h00, 32'h00000001);
		chk_rd(6'h2C, 32'h17FFEEC9);
		chk_rd(6'h18, 32'h00000000);
		foreach (rows[i]) begin
			wb(1'b1, rows[i].adr, rows[i].sel, rows[i].wdat, rd);
			chk_rd(rows[i].adr, rows[i].ex);
		end
		`CHK("keys", 64'h123456789ABCDEF0, {o_data_key, o_instr_key})
		`CHK("irq_sel", 60'hFFFFFFFFFFFFFFF, o_irq_src_sel)
		`CHK("links", 2'b11, {o_lockup_link, o_supply_link})
		`CHK("scramble", 2'b11, o_scramble_en)
		`CHK("access", 32'hFFFFEEC9, o_access)
		for (int m = 0; m < 4; m++) begin
			wr(6'h00, 32'(m));
			@(posedge i_core_clk);
			#1;
			`CHK("map_sel", 2'(m), o_map_sel)
			`CHK("map_onehot", (m == 3) ? 3'b001 : (m == 1) ? 3'b010 : 3'b100,
				{o_map_main, o_map_sys, o_map_sram})
		end
		for (int b = 0; b < 2; b++) begin
			wr(6'h00, 32'(b) << 6);
			for (int t = 0; t < 2; t++) begin
				@(posedge i_core_clk);
				i_ir_timer <= t[0];
				i_ir_serial <= !t[0];
				@(posedge i_core_clk);
				#1;
				`CHK("ir_env", b[0] ? !t[0] : t[0], o_ir_envelope)
			end
		end
		wr(6'h00, 32'h00290000);
		#1;
		`CHK("fastplus", 6'h29, o_fastplus)
		// Set then clear the remap bits so the default routing is re-seen.
		for (int k = 0; k < 3; k++) begin
			cfg = (k == 1) ? 32'h78400700 : 32'h0;
			wr(6'h00, cfg);
			for (int b = 0; b < 14; b++) begin
				@(posedge i_core_clk);
				i_req <= periph_req_type'(14'h1 << b);
				@(posedge i_core_clk);
				#1;
				`CHK("dma_req", route(cfg, i_req), o_dma_req)
			end
		end
		i_req <= '0;
		do_reset(2'b11);
		`CHK("map_onehot", 3'b001, {o_map_main, o_map_sys, o_map_sram})
		`CHK("links", 2'b00, {o_lockup_link, o_supply_link})
		chk_rd(6'h00, 32'h00000003);
		// A request made while the enable is low must wait for it.
		@(posedge i_core_clk);
		i_clk_en <= 1'b0;
		i_wb <= '{cyc:1'b1, stb:1'b1, we:1'b1, adr:6'h00, sel:4'hF,
			dat:32'h0};
		repeat (3) @(posedge i_core_clk);
		#1;
		`CHK("frozen", 3'b011, {o_wb_ack, o_map_sel})
		@(posedge i_core_clk);
		i_clk_en <= 1'b1;
		do begin
			@(posedge i_core_clk);
		end while (o_wb_ack !== 1'b1);
		i_wb.cyc <= 1'b0;
		i_wb.stb <= 1'b0;
		`CHK("map_sel", 2'b00, o_map_sel)
		stop_test();
	end

endmodule : system_config_remap_tb
